// ### design/core_pc_stack_memmap.v
/*
  Program counter, 16-deep return stack, interrupt context shadows, two
  indirect pointers with program-memory reads, and the flash address path.
  Assumes a synchronous instruction sequencer, a flash array that returns the
  word for the presented address within the same cycle, and a classic
  Wishbone master for the control and status registers.
*/
// Contract
// - Sixteen-entry, fifteen-bit hardware return stack.
// - Push overflow and pop underflow set flags.
// - Enabled stack error requests a software reset.
// - Two 16-bit pointers reach data and program.
// - Program-memory pointer read takes one extra cycle.
// - Pointers offer linear view of banked RAM.
// - Program counter is fifteen bits wide.
// - Addresses above implemented memory wrap around.
// - Reset starts at zero, interrupts at four.
// - Interrupt entry shadows context, return restores it.
// - Top 128 words form the endurance region.
// - Only low byte there has high endurance.
// - Pointer high bit seven selects program memory.
// - Program read loads low eight bits into W.
// - Pointer writes never alter program memory.
`timescale 1ns/1ns
`default_nettype none
`include "core_pc_stack_memmap_consts.vh"

module core_pc_stack_memmap (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        seq_advance,
  input  wire        seq_jump,
  input  wire [14:0] seq_jump_addr,
  input  wire        seq_call,
  input  wire        seq_return,
  input  wire        int_entry,
  input  wire        int_return,
  input  wire [31:0] ctx_in,
  output reg  [31:0] ctx_out,
  output reg         ctx_restore,
  input  wire        ind_req,
  input  wire        ind_sel,
  input  wire        ind_we,
  output wire        ind_busy,
  output reg         ind_done,
  output reg         ind_prog,
  output reg  [11:0] ind_data_addr,
  output reg         w_load,
  output reg  [7:0]  w_load_data,
  output wire [14:0] pfm_addr,
  input  wire [13:0] pfm_rdata,
  output wire        high_endurance_hit,
  output wire        high_endurance_low_byte,
  output reg         soft_reset_req
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_FETCH = 1'b1;

  reg [14:0] pc_q;
  reg [14:0] pc_d;
  reg [14:0] stack_mem [0:`STK_DEPTH-1];
  reg [4:0]  stk_ptr_q;
  reg [4:0]  stk_ptr_d;
  reg        push;
  reg        pop;
  reg [14:0] push_val;
  reg        ovf_ev;
  reg        unf_ev;
  reg        stack_overflow_flag_q;
  reg        stack_underflow_flag_q;
  reg [1:0]  ctrl_q;
  reg [15:0] ptr0_q;
  reg [15:0] ptr1_q;
  reg [15:0] shadow_ptr0_q;
  reg [15:0] shadow_ptr1_q;
  reg [31:0] shadow_ctx_q;
  reg        state_q;
  reg [14:0] fetch_addr_q;
  reg [31:0] rd_mux;
  wire [14:0] addr_mask;
  wire [14:0] pc_next_seq;
  wire [15:0] sel_ptr;
  wire        wb_req;
  wire        wb_wr;
  wire [12:0] lin_off;
  wire [4:0]  lin_bank;
  wire [12:0] lin_idx;
  wire [11:0] lin_addr;
  wire [11:0] data_addr;
  wire [12:0] lin_quot;
  wire [4:0]  stk_top;

  // Wrap-around by truncation to the implemented width.
  assign addr_mask   = ctrl_q[`CTRL_SIZE8K_BIT] ? `MASK_8K : `MASK_4K;
  assign pc_next_seq = (pc_q + 15'h0001) & addr_mask;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;

  // The flash sees the pointer address during the extra fetch cycle.
  assign pfm_addr = (state_q == ST_FETCH) ? fetch_addr_q : pc_q;
  assign ind_busy = (state_q == ST_FETCH);

  // Top 128 words of the implemented space; low byte only is endurant.
  assign high_endurance_hit      = (&pfm_addr[11:7]) & (~ctrl_q[`CTRL_SIZE8K_BIT] | pfm_addr[12]);
  assign high_endurance_low_byte = high_endurance_hit;

  // Linear view of the general purpose RAM across banks.
  assign sel_ptr   = ind_sel ? ptr1_q : ptr0_q;
  assign lin_off   = sel_ptr[12:0];
  assign lin_quot  = lin_off / `GPR_BANK_BYTES;
  assign lin_bank  = lin_quot[4:0];
  assign lin_idx   = lin_off % `GPR_BANK_BYTES;
  assign lin_addr  = {lin_bank, `GPR_BANK_OFFSET + lin_idx[6:0]};
  assign data_addr = (sel_ptr[15:13] == `LIN_BASE_TAG) ? lin_addr : sel_ptr[11:0];
  assign stk_top   = stk_ptr_q - 5'h01;

  // Program counter sequencing and stack requests.
  always @* begin
    pc_d     = pc_q;
    push     = 1'b0;
    pop      = 1'b0;
    push_val = pc_next_seq;
    if (int_entry) begin
      push     = 1'b1;
      push_val = pc_q;
      pc_d     = `INT_VECTOR;
    end else if (seq_call) begin
      push = 1'b1;
      pc_d = seq_jump_addr & addr_mask;
    end else if (seq_return | int_return) begin
      pop = 1'b1;
      if (stk_ptr_q != 5'h00) begin
        pc_d = stack_mem[stk_top[3:0]] & addr_mask;
      end
    end else if (seq_jump) begin
      pc_d = seq_jump_addr & addr_mask;
    end else if (seq_advance & (state_q == ST_IDLE)) begin
      pc_d = pc_next_seq;
    end
  end

  // Stack depth tracking and error events.
  always @* begin
    stk_ptr_d = stk_ptr_q;
    ovf_ev    = 1'b0;
    unf_ev    = 1'b0;
    if (push) begin
      if (stk_ptr_q == `STK_FULL) begin
        ovf_ev = 1'b1;
      end else begin
        stk_ptr_d = stk_ptr_q + 5'h01;
      end
    end else if (pop) begin
      if (stk_ptr_q == 5'h00) begin
        unf_ev = 1'b1;
      end else begin
        stk_ptr_d = stk_ptr_q - 5'h01;
      end
    end
  end

  always @(posedge mclk) begin
    if (push & (stk_ptr_q != `STK_FULL)) begin
      stack_mem[stk_ptr_q[3:0]] <= push_val;
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pc_q      <= `RESET_VECTOR;
      stk_ptr_q <= 5'h00;
    end else begin
      pc_q      <= pc_d;
      stk_ptr_q <= stk_ptr_d;
    end
  end

  // Sticky stack error flags; a new event beats a clear in the same cycle.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stack_overflow_flag_q  <= 1'b0;
      stack_underflow_flag_q <= 1'b0;
      soft_reset_req         <= 1'b0;
    end else begin
      if (ovf_ev) begin
        stack_overflow_flag_q <= 1'b1;
      end else if (wb_wr & (wb_adr_i == `OFF_POWER_CONTROL_REG) & wb_sel_i[0] & wb_dat_i[`POWER_CONTROL_REG_OVF_BIT]) begin
        stack_overflow_flag_q <= 1'b0;
      end
      if (unf_ev) begin
        stack_underflow_flag_q <= 1'b1;
      end else if (wb_wr & (wb_adr_i == `OFF_POWER_CONTROL_REG) & wb_sel_i[0] & wb_dat_i[`POWER_CONTROL_REG_UNF_BIT]) begin
        stack_underflow_flag_q <= 1'b0;
      end
      soft_reset_req <= (ovf_ev | unf_ev) & ctrl_q[`CTRL_STKRST_BIT];
    end
  end

  // Context shadows, saved on entry and restored on return.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shadow_ctx_q  <= 32'h0000_0000;
      shadow_ptr0_q <= 16'h0000;
      shadow_ptr1_q <= 16'h0000;
      ctx_out       <= 32'h0000_0000;
      ctx_restore   <= 1'b0;
    end else begin
      ctx_restore <= int_return & ~int_entry;
      if (int_entry) begin
        shadow_ctx_q  <= ctx_in;
        shadow_ptr0_q <= ptr0_q;
        shadow_ptr1_q <= ptr1_q;
      end else if (int_return) begin
        ctx_out <= shadow_ctx_q;
      end
    end
  end

  // Control register and the two pointers; interrupt return wins over the bus.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `CTRL_RESET;
      ptr0_q <= 16'h0000;
      ptr1_q <= 16'h0000;
    end else if (int_return & ~int_entry) begin
      ptr0_q <= shadow_ptr0_q;
      ptr1_q <= shadow_ptr1_q;
    end else if (wb_wr) begin
      if (wb_adr_i == `OFF_CTRL) begin
        if (wb_sel_i[0]) begin
          ctrl_q <= wb_dat_i[1:0];
        end
      end else if (wb_adr_i == `OFF_PTR0) begin
        if (wb_sel_i[0]) begin
          ptr0_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          ptr0_q[15:8] <= wb_dat_i[15:8];
        end
      end else if (wb_adr_i == `OFF_PTR1) begin
        if (wb_sel_i[0]) begin
          ptr1_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          ptr1_q[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // Indirect access sequencer; program reads take one extra cycle.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q       <= ST_IDLE;
      fetch_addr_q  <= 15'h0000;
      ind_done      <= 1'b0;
      ind_prog      <= 1'b0;
      ind_data_addr <= 12'h000;
      w_load        <= 1'b0;
      w_load_data   <= 8'h00;
    end else begin
      ind_done <= 1'b0;
      w_load   <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (ind_req) begin
            ind_prog <= sel_ptr[`PROG_SEL_BIT];
            if (sel_ptr[`PROG_SEL_BIT] & ~ind_we) begin
              fetch_addr_q <= sel_ptr[14:0] & addr_mask;
              state_q      <= ST_FETCH;
            end else begin
              ind_data_addr <= sel_ptr[`PROG_SEL_BIT] ? ind_data_addr : data_addr;
              ind_done      <= 1'b1;
            end
          end
        end
        ST_FETCH: begin
          w_load_data <= pfm_rdata[7:0];
          w_load      <= 1'b1;
          ind_done    <= 1'b1;
          state_q     <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Read data selection; unmapped offsets read as zero.
  always @* begin
    rd_mux = 32'h0000_0000;
    if (wb_adr_i == `OFF_CTRL) begin
      rd_mux = {30'h0000_0000, ctrl_q};
    end else if (wb_adr_i == `OFF_POWER_CONTROL_REG) begin
      rd_mux = {30'h0000_0000, stack_underflow_flag_q, stack_overflow_flag_q};
    end else if (wb_adr_i == `OFF_PC) begin
      rd_mux = {17'h00000, pc_q};
    end else if (wb_adr_i == `OFF_STKPTR) begin
      rd_mux = {27'h0000000, stk_ptr_q};
    end else if (wb_adr_i == `OFF_PTR0) begin
      rd_mux = {16'h0000, ptr0_q};
    end else if (wb_adr_i == `OFF_PTR1) begin
      rd_mux = {16'h0000, ptr1_q};
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req & ~wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

endmodule

`default_nettype wire

// ### design/core_pc_stack_memmap_consts.vh
/*
  Constants for the program counter, return stack and pointer block.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
`ifndef CORE_PC_STACK_MEMMAP_CONSTS_VH
`define CORE_PC_STACK_MEMMAP_CONSTS_VH

`define PC_W            15
`define STK_DEPTH       16
`define STK_FULL        5'h10
`define STK_PTR_W       5
`define PTR_W           16
`define RESET_VECTOR    15'h0000
`define INT_VECTOR      15'h0004
`define MASK_4K         15'h0fff
`define MASK_8K         15'h1fff
`define PROG_SEL_BIT    15
`define LIN_BASE_TAG    3'h1
`define GPR_BANK_BYTES  13'h0050
`define GPR_BANK_OFFSET 7'h20
`define GPR_BANK_COUNT  5'h1f

`define OFF_CTRL        8'h00
`define OFF_POWER_CONTROL_REG        8'h04
`define OFF_PC          8'h08
`define OFF_STKPTR      8'h0c
`define OFF_PTR0        8'h10
`define OFF_PTR1        8'h14

`define CTRL_STKRST_BIT 0
`define CTRL_SIZE8K_BIT 1
`define POWER_CONTROL_REG_OVF_BIT    0
`define POWER_CONTROL_REG_UNF_BIT    1
`define CTRL_RESET      2'h0

`endif

// ### sim/core_pc_stack_memmap_checker.sv
/*
  Concurrent checks on the ports of the program counter and pointer block.
  Assumes it is bound to every instance of core_pc_stack_memmap.
*/
`timescale 1ns/1ns
`default_nettype none
module core_pc_stack_memmap_checker (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        int_entry,
  input wire logic        int_return,
  input wire logic        ind_req,
  input wire logic        ind_busy,
  input wire logic        ind_done,
  input wire logic        ind_prog,
  input wire logic        w_load,
  input wire logic [7:0]  w_load_data,
  input wire logic [14:0] pfm_addr,
  input wire logic [13:0] pfm_rdata,
  input wire logic        high_endurance_hit,
  input wire logic        high_endurance_low_byte,
  input wire logic        ctx_restore
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence prog_fetch_s;
    ind_busy ##1 (ind_done && w_load && ind_prog);
  endsequence
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  prog_fetch_a: assert property (ind_busy |-> prog_fetch_s) else $error("fetch cycle wrong");
  busy_once_a: assert property (ind_busy |=> !ind_busy) else $error("busy too long");
  prog_low_byte_a: assert property (ind_busy |=> w_load_data == $past(pfm_rdata[7:0])) else $error("bad byte");
  int_vector_a: assert property (int_entry && !ind_req |=> pfm_addr == 15'h0004) else $error("bad vector");
  reset_vector_a: assert property ($rose(resetn) |-> pfm_addr == 15'h0000) else $error("bad start");
  addr_wrap_a: assert property (pfm_addr[14:13] == 2'h0) else $error("address not wrapped");
  he_range_a: assert property (high_endurance_hit |-> &pfm_addr[11:7]) else $error("hit outside top");
  he_low_byte_a: assert property (high_endurance_low_byte == high_endurance_hit) else $error("low byte flag");
  ctx_restore_a: assert property (int_return && !int_entry |=> ctx_restore) else $error("no restore");
endmodule
bind core_pc_stack_memmap core_pc_stack_memmap_checker u_chk (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .int_entry(int_entry), .int_return(int_return), .ind_req(ind_req),
  .ind_busy(ind_busy), .ind_done(ind_done), .ind_prog(ind_prog), .w_load(w_load), .w_load_data(w_load_data),
  .pfm_addr(pfm_addr), .pfm_rdata(pfm_rdata), .high_endurance_hit(high_endurance_hit),
  .high_endurance_low_byte(high_endurance_low_byte), .ctx_restore(ctx_restore));
`default_nettype wire

// ### sim/flash_model.sv
/*
  Program flash array model: returns a word for the presented address in the same cycle.
  Assumes the block truncates the address before presenting it.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_model (
  input  wire logic [14:0] addr,
  output logic      [13:0] rdata
);
  // The low byte differs from the address so a wrong fetch address shows up.
  assign rdata = {addr[13:8] ^ 6'h2a, addr[7:0] ^ 8'h5c};
endmodule
`default_nettype wire

// ### sim/tb_top.sv
/*
  Testbench: Wishbone register access, sequencer events and indirect accesses.
  Assumes the flash model answers in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic mclk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, adv = 0, jmp = 0, call = 0, ret = 0, ient = 0, iret = 0;
  logic ireq = 0, isel = 0, iwe = 0, srq_seen = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h3;
  logic [31:0] wdat = 32'h0, ctx_in = 32'h12345678, q;
  logic [14:0] jaddr = 15'h0;
  wire [31:0] rdat, ctx_out;
  wire [14:0] pfm_addr;
  wire [13:0] pfm_rdata;
  wire [11:0] daddr;
  wire [7:0] wdata;
  wire ack, ctx_rs, busy, done, prog, wld, hit, hlb, srq;
  integer error_cnt = 0, n_compared = 0, i, k;
  logic busy_seen, wld_seen;
  core_pc_stack_memmap dut (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .seq_advance(adv),
    .seq_jump(jmp), .seq_jump_addr(jaddr), .seq_call(call), .seq_return(ret), .int_entry(ient),
    .int_return(iret), .ctx_in(ctx_in), .ctx_out(ctx_out), .ctx_restore(ctx_rs), .ind_req(ireq), .ind_sel(isel),
    .ind_we(iwe), .ind_busy(busy), .ind_done(done), .ind_prog(prog), .ind_data_addr(daddr), .w_load(wld),
    .w_load_data(wdata), .pfm_addr(pfm_addr), .pfm_rdata(pfm_rdata), .high_endurance_hit(hit),
    .high_endurance_low_byte(hlb), .soft_reset_req(srq));
  flash_model u_flash (.addr(pfm_addr), .rdata(pfm_rdata));
  initial begin
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (srq === 1'b1) srq_seen <= 1'b1;
  end
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    k = 0;
    do begin @(posedge mclk); k++; end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 0; stb <= 0;
    if (k >= 20) begin error_cnt++; close_out; end
  endtask
  task seq(input logic [4:0] kind, input logic [14:0] a);
    @(posedge mclk);
    {ient, call, ret, jmp, iret} <= kind; jaddr <= a;
    @(posedge mclk);
    {ient, call, ret, jmp, iret} <= 5'h00;
  endtask
  task ind(input logic s, input logic w);
    @(posedge mclk);
    ireq <= 1; isel <= s; iwe <= w;
    @(posedge mclk);
    ireq <= 0; busy_seen = 0; wld_seen = 0; k = 0;
    do begin @(posedge mclk); k++; busy_seen |= (busy === 1'b1); wld_seen |= (wld === 1'b1); end
    while (done !== 1'b1 && k < 10);
    if (k >= 10) begin error_cnt++; close_out; end
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1;
    wb(0, 8'h08, 0); chk("pc", q, 32'h0);
    wb(0, 8'h30, 0); chk("unmapped", q, 32'h0);
    for (i = 0; i < 17; i++) seq(5'h08, 15'h0100);
    wb(0, 8'h0c, 0); chk("depth", q, 32'h10);
    wb(0, 8'h04, 0); chk("ovf", q, 32'h1);
    chk("no soft reset", srq_seen, 1'b0);
    for (i = 0; i < 17; i++) seq(5'h04, 15'h0);
    wb(0, 8'h04, 0); chk("unf", q, 32'h3);
    wb(0, 8'h08, 0); chk("ret pc", q, 32'h1);
    wb(1, 8'h04, 32'h3); wb(0, 8'h04, 0); chk("power_control_reg clear", q, 32'h0);
    wb(1, 8'h00, 32'h1); seq(5'h04, 15'h0); repeat (2) @(posedge mclk);
    chk("soft reset", srq_seen, 1'b1);
    seq(5'h02, 15'h7fff); wb(0, 8'h08, 0); chk("wrap 4k", q, 32'h0fff);
    chk("he hit", hit, 1'b1);
    chk("he low", hlb, 1'b1);
    wb(1, 8'h00, 32'h2); seq(5'h02, 15'h7fff); wb(0, 8'h08, 0); chk("wrap 8k", q, 32'h1fff);
    chk("he 8k", hit, 1'b1);
    wb(1, 8'h10, 32'h8123); ind(0, 0);
    chk("busy", busy_seen, 1'b1); chk("prog", prog, 1'b1);
    chk("w data", wdata, 8'h23 ^ 8'h5c);
    ind(0, 1); chk("no load", wld_seen, 1'b0); chk("prog wr", prog, 1'b1);
    wb(1, 8'h14, 32'h0345); ind(1, 0); chk("data addr", daddr, 12'h345); chk("no busy", busy_seen, 1'b0);
    wb(1, 8'h14, 32'h2055); ind(1, 1); chk("linear", daddr, 12'h0a5);
    seq(5'h10, 15'h0); wb(0, 8'h08, 0); chk("int vec", q, 32'h4);
    wb(1, 8'h10, 32'h0777); seq(5'h01, 15'h0); @(posedge mclk);
    chk("ctx", ctx_out, 32'h12345678);
    wb(0, 8'h10, 0); chk("ptr restore", q, 32'h8123);
    @(posedge mclk); resetn <= 0; repeat (2) @(posedge mclk); resetn <= 1;
    wb(0, 8'h08, 0); chk("pc reset", q, 32'h0);
    chk("he miss", hit, 1'b0);
    wb(0, 8'h04, 0); chk("power_control_reg reset", q, 32'h0);
    seq(5'h02, 15'h0ffe); adv <= 1; repeat (2) @(posedge mclk); adv <= 0;
    wb(0, 8'h08, 0); chk("adv wrap", q, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire
